//--- dpc_pkg.sv
package dpc_pkg;
    // geometry
    localparam int MEM_DW       = 8;
    localparam int RATE         = 2;
    localparam int LOC_DW       = MEM_DW * 2 * RATE;
    localparam int FIFO_DEPTH   = 16;
    localparam int LAT_W        = 5;
    // latencies shown after calibration passes, and before it
    localparam logic [4:0] WLAT_BASE = 5'h02;
    localparam logic [4:0] RLAT_BASE = 5'h0f;
    localparam logic [4:0] WLAT_RST  = 5'h00;
    localparam logic [4:0] RLAT_RST  = 5'h00;
    // calibration and reset release timing
    localparam int INIT_NS      = 200000;
    localparam int CLK_NS       = 10;
    localparam int INIT_CYC     = (INIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int CAL_READS    = 8;
    localparam int CAL_RD_GAP   = 4;
    localparam int RST_SYNC     = 2;
    localparam int RST_HOLD     = 4;

    typedef enum {
        DPC_CAL_RESET,
        DPC_CAL_INIT,
        DPC_CAL_READ,
        DPC_CAL_WAIT,
        DPC_CAL_DONE_OK,
        DPC_CAL_DONE_FAIL
    } dpc_cal_e;

    // one half-rate command cycle from the controller
    typedef struct packed {
        logic [1:0]        cs_n;
        logic [1:0]        dqs_burst;
        logic [1:0]        wdata_valid;
        logic [1:0]        doing_rd;
        logic [LOC_DW-1:0] wdata;
    } dpc_ctl_s;

    // one memory-side beat pair handed to the pad logic
    typedef struct packed {
        logic              cs_n;
        logic              dqs_en;
        logic              dq_oe;
        logic [2*MEM_DW-1:0] dq;
    } dpc_beat_s;

    // a read slot returned to the controller
    typedef struct packed {
        logic [1:0]        valid;
        logic [LOC_DW-1:0] data;
    } dpc_rd_s;
endpackage

//--- dpc_fifo.sv
`timescale 1ns/1ps
module dpc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_srst,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("dpc_fifo: depth must be a power of two, at least 2");
        end
    end

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wptr_r;
    logic [AW:0]      rptr_r;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    // an extra pointer bit tells full from empty
    assign full  = (wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]);
    assign empty = (wptr_r == rptr_r);
    assign push  = i_in_valid && !full;
    assign pop   = i_out_ready && !empty;

    assign o_in_ready  = !full;
    assign o_out_valid = !empty;
    assign o_out_data  = mem_r[rptr_r[AW-1:0]];

    // storage
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_r[wptr_r[AW-1:0]] <= i_in_data;
        end
    end

    // pointers
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wptr_r <= '0;
            rptr_r <= '0;
        end else begin
            if (push) begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (pop) begin
                rptr_r <= rptr_r + 1'b1;
            end
        end
    end
endmodule

//--- dpc_phy.sv
`timescale 1ns/1ps
module dpc_phy #(
    parameter int MEM_DW     = dpc_pkg::MEM_DW,
    parameter int FIFO_DEPTH = dpc_pkg::FIFO_DEPTH,
    parameter int INIT_CYC   = dpc_pkg::INIT_CYC,
    parameter logic [4:0] WLAT_CAL = dpc_pkg::WLAT_BASE,
    parameter logic [4:0] RLAT_CAL = dpc_pkg::RLAT_BASE
) (
    input  wire logic                        i_clk,
    input  wire logic                        i_srst,
    input  wire logic                        i_soft_reset_n,
    input  wire dpc_pkg::dpc_ctl_s           i_ctl,
    output logic                             o_ctl_ready,
    output logic                             o_reset_n,
    output logic                             o_cal_success,
    output logic                             o_cal_fail,
    output logic [4:0]                       o_wlat,
    output logic [4:0]                       o_rlat,
    output logic [1:0]                       o_rdata_valid,
    output logic [dpc_pkg::LOC_DW-1:0]       o_rdata,
    output logic                             o_mem_cs_n,
    output logic                             o_mem_dqs_en,
    output logic                             o_mem_dq_oe,
    output logic [MEM_DW-1:0]                o_mem_dq,
    input  wire logic [MEM_DW-1:0]           i_mem_dq,
    input  wire logic                        i_mem_cal_ok
);
    localparam int LDW = dpc_pkg::LOC_DW;
    localparam int BW  = $bits(dpc_pkg::dpc_beat_s);
    localparam int RDEPTH = 32;

    initial begin
        if (MEM_DW != dpc_pkg::MEM_DW) begin
            $error("dpc_phy: memory width must match package geometry");
        end
        if (INIT_CYC < 1) begin
            $error("dpc_phy: init count must be at least one");
        end
        if (RLAT_CAL == 5'h00) begin
            $error("dpc_phy: read latency must be at least one");
        end
    end

    // reset, sequencer and latency state
    logic [dpc_pkg::RST_SYNC-1:0] rst_sync_r;
    logic [2:0]                   hold_cnt_r;
    logic                         reset_n_r;
    logic                         seq_rst;
    dpc_pkg::dpc_cal_e            cal_r;
    logic [31:0]                  cal_cnt_r;
    logic [3:0]                   cal_rd_r;
    logic [3:0]                   cal_ok_cnt_r;
    logic                         cal_success_r;
    logic                         cal_fail_r;
    logic [4:0]                   wlat_r;
    logic [4:0]                   rlat_r;

    // release of reset is ripped through two stages before use
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rst_sync_r <= '0;
        end else begin
            rst_sync_r <= {rst_sync_r[dpc_pkg::RST_SYNC-2:0], 1'b1};
        end
    end

    // output reset held a few cycles after the synchronised release
    always_ff @(posedge i_clk) begin
        if (i_srst || !rst_sync_r[dpc_pkg::RST_SYNC-1]) begin
            hold_cnt_r <= '0;
            reset_n_r  <= 1'b0;
        end else if (hold_cnt_r != 3'(dpc_pkg::RST_HOLD)) begin
            hold_cnt_r <= hold_cnt_r + 3'h1;
        end else begin
            reset_n_r  <= 1'b1;
        end
    end

    // sequencer is held while recalibration request is low
    assign seq_rst = !reset_n_r || !i_soft_reset_n;

    // calibration sequencer
    always_ff @(posedge i_clk) begin
        if (seq_rst) begin
            cal_r        <= dpc_pkg::DPC_CAL_RESET;
            cal_cnt_r    <= '0;
            cal_rd_r     <= '0;
            cal_ok_cnt_r <= '0;
        end else begin
            case (cal_r)
                dpc_pkg::DPC_CAL_RESET: begin
                    cal_r     <= dpc_pkg::DPC_CAL_INIT;
                    cal_cnt_r <= '0;
                end
                dpc_pkg::DPC_CAL_INIT: begin
                    // memory power-up wait before first calibration read
                    if (cal_cnt_r == 32'(INIT_CYC - 1)) begin
                        cal_r     <= dpc_pkg::DPC_CAL_READ;
                        cal_cnt_r <= '0;
                    end else begin
                        cal_cnt_r <= cal_cnt_r + 32'h1;
                    end
                end
                dpc_pkg::DPC_CAL_READ: begin
                    // one calibration read; result sampled from the pad side
                    cal_rd_r  <= cal_rd_r + 4'h1;
                    cal_r     <= dpc_pkg::DPC_CAL_WAIT;
                    cal_cnt_r <= '0;
                    if (i_mem_cal_ok) begin
                        cal_ok_cnt_r <= cal_ok_cnt_r + 4'h1;
                    end
                end
                dpc_pkg::DPC_CAL_WAIT: begin
                    if (cal_cnt_r == 32'(dpc_pkg::CAL_RD_GAP - 1)) begin
                        if (cal_rd_r == 4'(dpc_pkg::CAL_READS)) begin
                            // every read must pass for a good result
                            cal_r <= (cal_ok_cnt_r == 4'(dpc_pkg::CAL_READS)) ?
                                     dpc_pkg::DPC_CAL_DONE_OK : dpc_pkg::DPC_CAL_DONE_FAIL;
                        end else begin
                            cal_r <= dpc_pkg::DPC_CAL_READ;
                        end
                    end else begin
                        cal_cnt_r <= cal_cnt_r + 32'h1;
                    end
                end
                dpc_pkg::DPC_CAL_DONE_OK: cal_r <= cal_r;
                dpc_pkg::DPC_CAL_DONE_FAIL: cal_r <= cal_r;
                default: cal_r <= dpc_pkg::DPC_CAL_RESET;
            endcase
        end
    end

    // result flags and advertised latencies
    always_ff @(posedge i_clk) begin
        if (seq_rst) begin
            cal_success_r <= 1'b0;
            cal_fail_r    <= 1'b0;
            wlat_r        <= dpc_pkg::WLAT_RST;
            rlat_r        <= dpc_pkg::RLAT_RST;
        end else if (cal_r == dpc_pkg::DPC_CAL_DONE_OK && !cal_success_r) begin
            cal_success_r <= 1'b1;
            wlat_r        <= WLAT_CAL;
            rlat_r        <= RLAT_CAL;
        end else if (cal_r == dpc_pkg::DPC_CAL_DONE_FAIL) begin
            cal_fail_r    <= 1'b1;
        end
    end

    // write path: half-rate cycle split into two beats into the fifo
    dpc_pkg::dpc_beat_s beat_lo;
    dpc_pkg::dpc_beat_s beat_hi;
    dpc_pkg::dpc_beat_s fifo_out;
    logic               fifo_in_ready;
    logic               fifo_out_valid;
    logic [BW-1:0]      fifo_out_raw;
    localparam int CW = $clog2(FIFO_DEPTH) + 1;
    logic               half_r;
    logic               out_half_r;
    logic               lo_go;
    logic               push_req;
    logic               pop;
    logic [CW-1:0]      cnt_r;

    // a beat that drives nothing on the pins is not worth a fifo slot
    function automatic logic beat_busy(input dpc_pkg::dpc_beat_s b);
        return !b.cs_n || b.dqs_en || b.dq_oe;
    endfunction

    // bit 0 lanes first: low two bytes in beat_lo, high two in beat_hi
    always_comb begin
        beat_lo.cs_n   = i_ctl.cs_n[0];
        beat_lo.dqs_en = i_ctl.dqs_burst[0];
        beat_lo.dq_oe  = i_ctl.wdata_valid[0];
        beat_lo.dq     = i_ctl.wdata[2*MEM_DW-1:0];
        beat_hi.cs_n   = i_ctl.cs_n[1];
        beat_hi.dqs_en = i_ctl.dqs_burst[1];
        beat_hi.dq_oe  = i_ctl.wdata_valid[1];
        beat_hi.dq     = i_ctl.wdata[LDW-1:2*MEM_DW];
    end

    // lo step starts only with room for both beats, so the hi step never stalls
    assign lo_go    = !half_r && (cnt_r <= CW'(FIFO_DEPTH - 2));
    assign push_req = half_r ? beat_busy(beat_hi) : (lo_go && beat_busy(beat_lo));
    assign pop      = fifo_out_valid && !out_half_r;

    // lo step then hi step for every controller word
    always_ff @(posedge i_clk) begin
        if (!reset_n_r) begin
            half_r <= 1'b0;
        end else if (half_r || lo_go) begin
            half_r <= !half_r;
        end
    end

    // occupancy kept here; the fifo only tells full from empty
    always_ff @(posedge i_clk) begin
        if (!reset_n_r) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + CW'(push_req && fifo_in_ready) - CW'(pop);
        end
    end

    // memory side takes one beat per two clocks, one byte each clock
    always_ff @(posedge i_clk) begin
        if (!reset_n_r) begin
            out_half_r <= 1'b0;
        end else begin
            out_half_r <= pop;
        end
    end

    logic [BW-1:0] fifo_in;
    assign fifo_in = half_r ? beat_hi : beat_lo;

    dpc_fifo #(
        .WIDTH (BW),
        .DEPTH (FIFO_DEPTH)
    ) u_wfifo (
        .i_clk       (i_clk),
        .i_srst      (!reset_n_r),
        .i_in_valid  (push_req),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (fifo_in),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (!out_half_r),
        .o_out_data  (fifo_out_raw)
    );
    assign fifo_out = fifo_out_raw;

    // ready stands through the hi step; the word is taken at its end
    logic ctl_ready_r;
    always_ff @(posedge i_clk) begin
        if (!reset_n_r) begin
            ctl_ready_r <= 1'b0;
        end else begin
            ctl_ready_r <= lo_go;
        end
    end

    // memory-side beat: one memory data byte per half of the popped beat
    logic                 mem_cs_n_r;
    logic                 mem_dqs_en_r;
    logic                 mem_dq_oe_r;
    logic [MEM_DW-1:0]    mem_dq_r;
    logic [MEM_DW-1:0]    dq_hi_r;
    always_ff @(posedge i_clk) begin
        if (!reset_n_r) begin
            mem_cs_n_r   <= 1'b1;
            mem_dqs_en_r <= 1'b0;
            mem_dq_oe_r  <= 1'b0;
            mem_dq_r     <= '0;
            dq_hi_r      <= '0;
        end else if (pop) begin
            mem_cs_n_r   <= fifo_out.cs_n;
            mem_dqs_en_r <= fifo_out.dqs_en;
            // unused halves of an unaligned burst are simply not driven
            mem_dq_oe_r  <= fifo_out.dq_oe;
            mem_dq_r     <= fifo_out.dq[MEM_DW-1:0];
            dq_hi_r      <= fifo_out.dq[2*MEM_DW-1:MEM_DW];
        end else if (out_half_r) begin
            // second byte of the same beat; command pin is one-shot
            mem_cs_n_r   <= 1'b1;
            mem_dq_r     <= dq_hi_r;
        end else begin
            mem_cs_n_r   <= 1'b1;
            mem_dqs_en_r <= 1'b0;
            mem_dq_oe_r  <= 1'b0;
        end
    end

    // read path: window flag delayed by advertised read latency
    logic [1:0]     rd_pipe_r [RDEPTH];
    logic [LDW-1:0] rdata_cap_r;
    logic [1:0]     rvalid_r;
    logic [LDW-1:0] rdata_r;

    // shift line of read window pairs, per-lane pattern kept intact
    always_ff @(posedge i_clk) begin
        if (!reset_n_r) begin
            for (int k = 0; k < RDEPTH; k++) begin
                rd_pipe_r[k] <= 2'h0;
            end
        end else begin
            rd_pipe_r[0] <= i_ctl.doing_rd;
            for (int k = 1; k < RDEPTH; k++) begin
                rd_pipe_r[k] <= rd_pipe_r[k-1];
            end
        end
    end

    // capture returning bytes into a half-rate word, low half first
    always_ff @(posedge i_clk) begin
        if (!reset_n_r) begin
            rdata_cap_r <= '0;
        end else begin
            rdata_cap_r <= {i_mem_dq, rdata_cap_r[LDW-1:MEM_DW]};
        end
    end

    // the line adds one stage and this register another, hence the tap at rlat-2
    always_ff @(posedge i_clk) begin
        if (!reset_n_r || !cal_success_r || rlat_r == 5'h00) begin
            rvalid_r <= 2'h0;
            rdata_r  <= '0;
        end else begin
            rvalid_r <= (rlat_r == 5'h01) ? i_ctl.doing_rd : rd_pipe_r[rlat_r - 5'h2];
            rdata_r  <= rdata_cap_r;
        end
    end

    assign o_ctl_ready   = ctl_ready_r;
    assign o_reset_n     = reset_n_r;
    assign o_cal_success = cal_success_r;
    assign o_cal_fail    = cal_fail_r;
    assign o_wlat        = wlat_r;
    assign o_rlat        = rlat_r;
    assign o_rdata_valid = rvalid_r;
    assign o_rdata       = rdata_r;
    assign o_mem_cs_n    = mem_cs_n_r;
    assign o_mem_dqs_en  = mem_dqs_en_r;
    assign o_mem_dq_oe   = mem_dq_oe_r;
    assign o_mem_dq      = mem_dq_r;
endmodule

//--- dpc_phy_assertions.sv
`timescale 1ns/1ps
// watches the controller-facing ports of the phy
module dpc_phy_chk #(
    parameter logic [4:0] WLAT_CAL = 5'h02,
    parameter logic [4:0] RLAT_CAL = 5'h0f
) (
    input  wire logic              i_clk,
    input  wire logic              i_srst,
    input  wire logic              i_soft_reset_n,
    input  wire dpc_pkg::dpc_ctl_s i_ctl,
    input  wire logic              o_reset_n,
    input  wire logic              o_cal_success,
    input  wire logic              o_cal_fail,
    input  wire logic [4:0]        o_wlat,
    input  wire logic [4:0]        o_rlat,
    input  wire logic [1:0]        o_rdata_valid
);
    logic [5:0] ok_cnt_r;

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);

    // cycles since success; the copy check needs a full history behind it
    always_ff @(posedge i_clk) begin
        if (i_srst || !o_cal_success) begin
            ok_cnt_r <= 6'h00;
        end else if (ok_cnt_r != 6'h3f) begin
            ok_cnt_r <= ok_cnt_r + 6'h01;
        end
    end

    sequence s_cal_start;
        $rose(o_reset_n && i_soft_reset_n);
    endsequence
    sequence s_cal_done;
        o_cal_success || o_cal_fail;
    endsequence

    chk_rdv_copy: assert property (
        ok_cnt_r > 6'h12 |-> o_rdata_valid == $past(i_ctl.doing_rd, RLAT_CAL))
        else $error("read valid is not the delayed read window");
    chk_rdv_refused: assert property (
        !o_cal_success && !$past(o_cal_success) |-> o_rdata_valid == 2'h0)
        else $error("read valid before calibration");
    chk_lat_idle: assert property (
        !o_cal_success && !$past(o_cal_success) |-> o_wlat == 5'h00 && o_rlat == 5'h00)
        else $error("latency shown before calibration");
    chk_lat_value: assert property (
        o_cal_success && $past(o_cal_success) |-> o_wlat == WLAT_CAL && o_rlat == RLAT_CAL)
        else $error("latency differs from calibrated value");
    chk_lat_const: assert property (
        o_cal_success && $past(o_cal_success) |-> $stable(o_wlat) && $stable(o_rlat))
        else $error("latency changed in normal operation");
    chk_flag_excl: assert property (
        !(o_cal_success && o_cal_fail))
        else $error("pass and fail both high");
    chk_soft_hold: assert property (
        !i_soft_reset_n [*3] |-> !o_cal_success && !o_cal_fail)
        else $error("calibration flag during recalibration hold");
    chk_rst_release: assert property (
        $fell(i_srst) |-> !o_reset_n [*4] ##[1:12] o_reset_n)
        else $error("reset output release timing wrong");
    chk_idle_in_rst: assert property (
        !o_reset_n |-> !o_cal_success && !o_cal_fail)
        else $error("calibration flag while reset out low");
    chk_cal_quiet: assert property (
        s_cal_start |-> !o_cal_success [*8])
        else $error("calibration finished too early");
    chk_cal_ends: assert property (
        s_cal_start |-> ##[8:400] s_cal_done)
        else $error("calibration never finished");
endmodule

bind dpc_phy dpc_phy_chk #(
    .WLAT_CAL(WLAT_CAL),
    .RLAT_CAL(RLAT_CAL)
) u_chk (
    .i_clk         (i_clk),
    .i_srst        (i_srst),
    .i_soft_reset_n(i_soft_reset_n),
    .i_ctl         (i_ctl),
    .o_reset_n     (o_reset_n),
    .o_cal_success (o_cal_success),
    .o_cal_fail    (o_cal_fail),
    .o_wlat        (o_wlat),
    .o_rlat        (o_rlat),
    .o_rdata_valid (o_rdata_valid)
);

//--- dpc_ctl_model.sv
`timescale 1ns/1ps
// controller model: plays one command per go pulse; bit 0 is the earlier
// memory cycle of each pair
module dpc_ctl_model (
    input  wire logic         i_clk,
    input  wire logic         i_srst,
    input  wire logic         i_go,
    input  wire logic [1:0]   i_kind,
    input  wire logic [4:0]   i_len,
    input  wire logic         i_cal_ok,
    input  wire logic         i_ready,
    input  wire logic [4:0]   i_wlat,
    output dpc_pkg::dpc_ctl_s o_ctl
);
    logic [5:0] t_r;
    logic       run_r;
    logic [5:0] d;
    logic [5:0] n;

    // step counter; a go before calibration passed is ignored
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            run_r <= 1'b0;
            t_r   <= 6'h00;
        end else if (i_go && i_cal_ok && !run_r) begin
            run_r <= 1'b1;
            t_r   <= 6'h00;
        end else if (run_r && (i_kind[1] || i_ready)) begin
            // a write word stands until the phy takes it
            t_r <= t_r + 6'h01;
            if (t_r > 6'(i_wlat) + 6'(i_len) + 6'h03) run_r <= 1'b0;
        end
    end

    // command table; write bytes count up so order shows on the pins
    always_comb begin
        d = t_r - 6'(i_wlat);
        n = 6'(i_len);
        o_ctl = '0;
        o_ctl.cs_n = 2'h3;
        o_ctl.wdata = {d, 2'h3, d, 2'h2, d, 2'h1, d, 2'h0};
        if (run_r) begin
            case (i_kind)
                2'h0: begin
                    if (t_r == 6'h00) o_ctl.cs_n = 2'h1;
                    if (d == 6'h3f) o_ctl.dqs_burst = 2'h2;
                    if (d < n) o_ctl.dqs_burst = 2'h3;
                    if (d < n) o_ctl.wdata_valid = 2'h3;
                end
                2'h1: begin
                    if (t_r == 6'h00) o_ctl.cs_n = 2'h2;
                    if (d < n) o_ctl.dqs_burst = 2'h3;
                    if (d == n) o_ctl.dqs_burst = 2'h1;
                    if (d == 6'h00) o_ctl.wdata_valid = 2'h2;
                    else if (d < n) o_ctl.wdata_valid = 2'h3;
                    else if (d == n) o_ctl.wdata_valid = 2'h1;
                end
                2'h2: begin
                    if (t_r == 6'h00) o_ctl.cs_n = 2'h1;
                    if (t_r < n) o_ctl.doing_rd = 2'h3;
                end
                default: begin
                    if (t_r == 6'h01) o_ctl.cs_n = 2'h2;
                    if (t_r == 6'h00) o_ctl.doing_rd = 2'h2;
                    else if (t_r < n) o_ctl.doing_rd = 2'h3;
                    else if (t_r == n) o_ctl.doing_rd = 2'h1;
                end
            endcase
        end
    end
endmodule

//--- tb.sv
`timescale 1ns/1ps
module tb;
    logic              i_clk;
    logic              i_srst;
    logic              soft_n;
    logic              go;
    logic              cal_ok;
    logic [1:0]        kind;
    logic [4:0]        len;
    logic [7:0]        mem_dq;
    dpc_pkg::dpc_ctl_s ctl;
    logic              ready;
    logic              rst_n;
    logic              c_ok;
    logic              c_fail;
    logic              oe;
    logic [4:0]        wlat;
    logic [4:0]        rlat;
    logic [1:0]        rdv;
    logic [7:0]        dq;
    logic [31:0]       rdata;
    logic              dqs;
    logic              mcs;
    int                miscompares;
    int                check_count;

    // short init count keeps calibration quick
    dpc_phy #(.INIT_CYC(10)) dut (
        .i_clk(i_clk), .i_srst(i_srst), .i_soft_reset_n(soft_n), .i_ctl(ctl),
        .o_ctl_ready(ready), .o_reset_n(rst_n), .o_cal_success(c_ok),
        .o_cal_fail(c_fail), .o_wlat(wlat), .o_rlat(rlat), .o_rdata_valid(rdv),
        .o_rdata(rdata), .o_mem_cs_n(mcs), .o_mem_dqs_en(dqs), .o_mem_dq_oe(oe),
        .o_mem_dq(dq), .i_mem_dq(mem_dq), .i_mem_cal_ok(cal_ok));

    dpc_ctl_model u_ctl (
        .i_clk(i_clk), .i_srst(i_srst), .i_go(go), .i_kind(kind), .i_len(len),
        .i_cal_ok(c_ok), .i_ready(ready), .i_wlat(wlat), .o_ctl(ctl));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // returned byte changes every cycle so stale data never looks valid
    always @(posedge i_clk) mem_dq <= #1 mem_dq + 8'h01;

    task automatic tick(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic issue(input logic [1:0] k, input logic [4:0] l);
        kind = k;
        len = l;
        go = 1'b1;
        tick(1);
        go = 1'b0;
    endtask

    task automatic cal_wait(input logic pass);
        int w;
        w = 0;
        while (c_ok !== 1'b1 && c_fail !== 1'b1 && w < 400) begin
            tick(1);
            w++;
        end
        tick(2);
        chk(c_ok, pass, "cal pass");
        chk(c_fail, !pass, "cal fail");
        chk(wlat, pass ? 5'h02 : 5'h00, "wlat");
        chk(rlat, pass ? 5'h0f : 5'h00, "rlat");
    endtask

    task automatic t_write(input logic [1:0] k, input logic [7:0] first);
        logic [7:0] q[$];
        int         ncs;
        logic       prev_dqs;
        logic       lead;
        ncs = 0;
        prev_dqs = 1'b0;
        lead = 1'b0;
        for (int i = 0; i < 60; i++) begin
            if (i == 0) issue(k, 5'h02);
            if (oe === 1'b1 && q.size() == 0) lead = prev_dqs;
            if (oe === 1'b1) q.push_back(dq);
            if (mcs === 1'b0) ncs++;
            prev_dqs = dqs;
            tick(1);
        end
        chk(ncs, 1, "one command beat");
        chk(lead, 1'b1, "dqs leads data");
        chk(q.size(), 8, "byte count");
        foreach (q[i]) chk(q[i], first + 8'(i), "byte order");
    endtask

    task automatic t_read(input logic [1:0] k, input logic [5:0] pat);
        int         a;
        int         b;
        logic [5:0] got;
        logic [7:0] span;
        a = -1;
        b = -1;
        got = 6'h00;
        span = 8'h00;
        issue(k, 5'h02);
        for (int i = 0; i < 60; i++) begin
            if (a < 0 && ctl.doing_rd != 2'h0) a = i;
            if (b < 0 && rdv != 2'h0) begin
                b = i;
                span = 8'(rdata[31:24] - rdata[7:0]);
            end
            if (b >= 0 && i - b < 3) got = {got[3:0], rdv};
            tick(1);
        end
        chk(b - a, 15, "read latency");
        chk(got, pat, "read valid pattern");
        chk(span, 8'h03, "read bytes low first");
    endtask

    task automatic t_fill();
        int run;
        int gap;
        run = 0;
        gap = 0;
        issue(2'h0, 5'h18);
        for (int i = 0; i < 200; i++) begin
            run = (ready === 1'b1) ? 0 : run + 1;
            if (run > gap) gap = run;
            tick(1);
        end
        chk(gap > 2, 1'b1, "fifo refused when full");
        chk(oe, 1'b0, "fifo drained");
    endtask

    task automatic t_recal();
        cal_ok = 1'b0;
        soft_n = 1'b0;
        tick(5);
        chk(c_ok, 1'b0, "held in recal");
        soft_n = 1'b1;
        cal_wait(1'b0);
        cal_ok = 1'b1;
        soft_n = 1'b0;
        tick(5);
        soft_n = 1'b1;
        cal_wait(1'b1);
        t_read(2'h2, 6'h3c);
    endtask

    initial begin
        #200000;
        miscompares++;
        $display("[ERR] %0t watchdog expired", $time);
        wrap_up();
    end

    initial begin
        i_srst = 1'b1;
        soft_n = 1'b1;
        go = 1'b0;
        cal_ok = 1'b1;
        kind = 2'h0;
        len = 5'h02;
        mem_dq = 8'h00;
        miscompares = 0;
        check_count = 0;
        tick(20);
        chk(rst_n, 1'b0, "reset out in reset");
        i_srst = 1'b0;
        cal_wait(1'b1);
        chk(rst_n, 1'b1, "reset out released");
        t_write(2'h0, 8'h00);
        t_write(2'h1, 8'h02);
        t_read(2'h2, 6'h3c);
        t_read(2'h3, 6'h2d);
        t_fill();
        t_recal();
        wrap_up();
    end
endmodule
